// ### logic/rlm_cfg.svh
`ifndef RLM_CFG_SVH
`define RLM_CFG_SVH
// ==========================================================
// Register word indices; byte address is index times four
`define RLM_IDX_LGA        8'h58
`define RLM_IDX_LDAC       8'h59
`define RLM_IDX_LINE_IN2   8'h5a
`define RLM_IDX_RGA        8'h5b
`define RLM_IDX_RDAC       8'h5c
`define RLM_IDX_LEVEL      8'h5d
`define RLM_IDX_PWR        8'h5e
`define RLM_IDX_SHORT      8'h5f
`define RLM_IDX_IRQ_STAT   8'h60
`define RLM_IDX_IRQ_MASK   8'h61
// ==========================================================
// Field positions, level limit and reset values
`define RLM_ROUTE_BIT      7
`define RLM_LEVEL_MSB      7
`define RLM_LEVEL_LSB      4
`define RLM_MUTE_BIT       3
`define RLM_PEND_BIT       1
`define RLM_PWRUP_BIT      0
`define RLM_LEVEL_MAX      4'h9
`define RLM_MIX_RESET      8'h00
`define RLM_LEVEL_RESET    8'h00
// Cycles from a gain write until it counts as applied
`define RLM_APPLY_CYCLES   8'h10
`endif

// ### logic/rlm_pkg.sv
package rlm_pkg;
  // Mixer source control: route bit and attenuation
  typedef struct packed {
    logic       route;
    logic [6:0] atten;
  } rlm_mix_s;

  typedef enum logic [0:0] {
    RLM_IDLE = 1'b0,
    RLM_DATA = 1'b1
  } rlm_phase_e;

  // Hardware status inputs
  typedef struct packed {
    logic left_dac_up;
    logic right_dac_up;
    logic left_line_out_up;
    logic right_line_out_up;
    logic left_headphone_up;
    logic right_headphone_up;
    logic headphone_common_up;
    logic left_headphone_short;
    logic right_headphone_short;
    logic headphone_common_short;
  } rlm_hw_s;

  // Whole module state
  typedef struct packed {
    rlm_mix_s [4:0] mix;
    logic [3:0]     level;
    logic           unmute;
    logic [7:0]     apply_cnt;
    rlm_phase_e     phase;
    logic           wr;
    logic [7:0]     idx;
    logic [31:0]    rdata;
    logic [2:0]     short_prev;
    logic [2:0]     irq_stat;
    logic [2:0]     irq_mask;
  } rlm_state_s;
endpackage : rlm_pkg

// ### logic/rlm_right_mixer_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "rlm_cfg.svh"

module rlm_right_mixer_regs
  import rlm_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic        CLK_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire rlm_hw_s     HW_STATUS,
  output rlm_mix_s  [4:0]  MIX_CTRL,
  output logic      [3:0]  LEVEL_DB,
  output logic             UNMUTE,
  output logic             IRQ
);

  rlm_state_s s_q;
  rlm_state_s s_d;
  logic [7:0] level_rd;
  logic [7:0] pwr_rd;
  logic [7:0] short_rd;
  logic [2:0] short_now;
  logic       take;

  // ==========================================================
  // Live read views of the status registers
  assign short_now = {HW_STATUS.left_headphone_short, HW_STATUS.right_headphone_short,
                      HW_STATUS.headphone_common_short};
  assign level_rd = {s_q.level, s_q.unmute, 1'b0,
                     (s_q.apply_cnt != 8'h00),
                     HW_STATUS.right_line_out_up};
  assign pwr_rd = {HW_STATUS.left_dac_up, HW_STATUS.right_dac_up, 1'b0,
                   HW_STATUS.left_line_out_up, HW_STATUS.right_line_out_up,
                   HW_STATUS.left_headphone_up, HW_STATUS.right_headphone_up, 1'b0};
  assign short_rd = {short_now, 1'b0,
                     HW_STATUS.headphone_common_up,
                     3'h0};

  assign take = HSEL & HREADY & HTRANS[1];

  // ==========================================================
  // Next state: bus decode, register writes, interrupts
  always_comb begin
    s_d = s_q;
    s_d.short_prev = short_now;
    // Short rising edges are events
    s_d.irq_stat = s_q.irq_stat;
    if (s_q.apply_cnt != 8'h00) begin
      s_d.apply_cnt = s_q.apply_cnt - 8'h01;
    end
    // Data phase of a write
    if (s_q.phase == RLM_DATA && s_q.wr) begin
      case (s_q.idx)
        `RLM_IDX_LGA, `RLM_IDX_LDAC, `RLM_IDX_LINE_IN2, `RLM_IDX_RGA, `RLM_IDX_RDAC: begin
          s_d.mix[3'(s_q.idx - `RLM_IDX_LGA)] = rlm_mix_s'(HWDATA[7:0]);
          s_d.apply_cnt = `RLM_APPLY_CYCLES;
        end
        `RLM_IDX_LEVEL: begin
          s_d.level = HWDATA[`RLM_LEVEL_MSB:`RLM_LEVEL_LSB];
          s_d.unmute = HWDATA[`RLM_MUTE_BIT];
          s_d.apply_cnt = `RLM_APPLY_CYCLES;
        end
        `RLM_IDX_IRQ_MASK: begin
          s_d.irq_mask = HWDATA[2:0];
        end
        default: begin
          s_d.irq_mask = s_q.irq_mask;
        end
      endcase
    end
    // Read of status clears it; set wins below
    if (take && !HWRITE && HADDR[9:2] == `RLM_IDX_IRQ_STAT) begin
      s_d.irq_stat = 3'h0;
    end
    s_d.irq_stat = s_d.irq_stat | (short_now & ~s_q.short_prev);
    // Address phase
    s_d.phase = RLM_IDLE;
    s_d.rdata = 32'h0;
    if (take) begin
      s_d.phase = RLM_DATA;
      s_d.wr = HWRITE;
      s_d.idx = HADDR[9:2];
      if (!HWRITE) begin
        case (HADDR[9:2])
          `RLM_IDX_LGA, `RLM_IDX_LDAC, `RLM_IDX_LINE_IN2, `RLM_IDX_RGA, `RLM_IDX_RDAC: begin
            s_d.rdata = {24'h0, s_q.mix[3'(HADDR[9:2] - `RLM_IDX_LGA)]};
          end
          `RLM_IDX_LEVEL:    s_d.rdata = {24'h0, level_rd};
          `RLM_IDX_PWR:      s_d.rdata = {24'h0, pwr_rd};
          `RLM_IDX_SHORT:    s_d.rdata = {24'h0, short_rd};
          `RLM_IDX_IRQ_STAT: s_d.rdata = {29'h0, s_q.irq_stat};
          `RLM_IDX_IRQ_MASK: s_d.rdata = {29'h0, s_q.irq_mask};
          default:           s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      s_q <= '0;
      s_q.apply_cnt <= `RLM_APPLY_CYCLES;
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign MIX_CTRL = s_q.mix;
  assign LEVEL_DB = (s_q.level > `RLM_LEVEL_MAX) ? `RLM_LEVEL_MAX : s_q.level;
  assign UNMUTE = s_q.unmute;
  assign IRQ = |(s_q.irq_stat & s_q.irq_mask);

endmodule : rlm_right_mixer_regs
`default_nettype wire

// ### tb/rlm_right_mixer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rlm_right_mixer_chk
  import rlm_pkg::*;
(
  input wire logic           CORE_CLK,
  input wire logic           NRST,
  input wire logic           CLK_EN,
  input wire logic           HSEL,
  input wire logic [31:0]    HADDR,
  input wire logic [1:0]     HTRANS,
  input wire logic           HWRITE,
  input wire logic [31:0]    HWDATA,
  input wire logic           HREADY,
  input wire logic [31:0]    HRDATA,
  input wire rlm_hw_s        HW_STATUS,
  input wire rlm_mix_s [4:0] MIX_CTRL,
  input wire logic [3:0]     LEVEL_DB,
  input wire logic           UNMUTE
);
  logic        wr_q;
  logic        rd_q;
  logic [31:0] a_q;
  // ==========================================================
  // Data-phase tracking
  always_ff @(posedge CORE_CLK) begin
    wr_q <= NRST && CLK_EN && HSEL && HREADY && HTRANS[1] && HWRITE;
    rd_q <= NRST && CLK_EN && HSEL && HREADY && HTRANS[1] && !HWRITE;
    if (CLK_EN) a_q <= HADDR;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  reset_vals_a: assert property ($rose(NRST) |-> MIX_CTRL == '0 && !UNMUTE && LEVEL_DB == 4'h0)
    else $error("reset values");
  level_range_a: assert property (LEVEL_DB <= 4'h9) else $error("level range");
  ctrl_hold_a: assert property (!wr_q |=> $stable({MIX_CTRL, LEVEL_DB, UNMUTE})) else $error("ctrl moved");
  mix_write_a: assert property (wr_q && CLK_EN && a_q == 32'h160 |=> MIX_CTRL[0] == $past(HWDATA[7:0]))
    else $error("mix write");
  unmute_write_a: assert property (wr_q && CLK_EN && a_q == 32'h174 |=> UNMUTE == $past(HWDATA[3]))
    else $error("mute write");
  pwr_read_a: assert property (rd_q && a_q == 32'h178 |->
    HRDATA == {24'h0, $past(HW_STATUS[9:8]), 1'b0, $past(HW_STATUS[7:4]), 1'b0}) else $error("power read");
  short_read_a: assert property (rd_q && a_q == 32'h17c |->
    HRDATA == {24'h0, $past(HW_STATUS[2:0]), 1'b0, $past(HW_STATUS[3]), 3'h0}) else $error("short read");
  level_read_a: assert property (rd_q && a_q == 32'h174 |-> !HRDATA[2] && HRDATA[0] == $past(HW_STATUS[6]))
    else $error("level read");
endmodule : rlm_right_mixer_chk
bind rlm_right_mixer_regs rlm_right_mixer_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .CLK_EN(CLK_EN),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .HW_STATUS(HW_STATUS), .MIX_CTRL(MIX_CTRL), .LEVEL_DB(LEVEL_DB), .UNMUTE(UNMUTE));
`default_nettype wire

// ### tb/rlm_right_mixer_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rlm_right_mixer_regs_tb
  import rlm_pkg::*;
;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, rdy, unmute, irq, hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [3:0] lvl;
  rlm_hw_s hw = '0;
  rlm_mix_s [4:0] mix;
  int failures = 0, n_tests = 0;
  always #50 clk = ~clk;
  rlm_right_mixer_regs u_dut (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(1'b1), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
    .HREADYOUT(rdy), .HRESP(hresp), .HW_STATUS(hw), .MIX_CTRL(mix), .LEVEL_DB(lvl), .UNMUTE(unmute), .IRQ(irq));
  // ==========================================================
  // Bus and compare helpers
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task xf(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    logic k;
    hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= a;
    do begin @(negedge clk); k = rdy; @(posedge clk); end while (k !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do begin @(negedge clk); k = rdy; r = hrdata; @(posedge clk); end while (k !== 1'b1);
  endtask : xf
  task rc(input logic [31:0] a, e);
    xf(0, a, 0, q);
    chk(q, e);
  endtask : rc
  // Scenarios
  task t_mix;
    for (int i = 0; i < 5; i++) rc(32'h160 + 4 * i, 0);
    rc(32'h174, 32'h2);
    rc(32'h188, 0);
    chk({rdy, hresp}, 2'b10);
    for (int i = 0; i < 5; i++) xf(1, 32'h160 + 4 * i, 32'h80 | i * 9, q);
    for (int i = 0; i < 5; i++) begin
      rc(32'h160 + 4 * i, 32'h80 | i * 9);
      chk(mix[i], 32'h80 | i * 9);
    end
    xf(1, 32'h160, 32'h7f, q);
    rc(32'h160, 32'h7f);
    $display("mix test done");
  endtask : t_mix
  task t_level;
    xf(1, 32'h174, 32'h9c, q);
    rc(32'h174, 32'h9a);
    chk({lvl, unmute}, 5'h13);
    repeat (20) @(posedge clk);
    hw.right_line_out_up <= 1;
    rc(32'h174, 32'h99);
    xf(1, 32'h174, 32'h30, q);
    rc(32'h174, 32'h33);
    chk({lvl, unmute}, 5'h06);
    $display("level test done");
  endtask : t_level
  task t_stat;
    rlm_hw_s p;
    for (int i = 0; i < 2; i++) begin
      p = i ? 10'h14a : 10'h2b5;
      hw <= p;
      xf(1, 32'h178, 32'hff, q);
      rc(32'h178, {24'h0, p[9:8], 1'b0, p[7:4], 1'b0});
      rc(32'h17c, {24'h0, p[2:0], 1'b0, p[3], 3'h0});
    end
    $display("status test done");
  endtask : t_stat
  task t_irq;
    hw <= '0;
    xf(0, 32'h180, 0, q);
    xf(1, 32'h184, 32'h4, q);
    hw.right_headphone_short <= 1;
    repeat (4) @(posedge clk);
    chk(irq, 0);
    hw.left_headphone_short <= 1;
    for (int k = 0; k < 10 && irq !== 1'b1; k++) @(posedge clk);
    chk(irq, 1);
    rc(32'h180, 32'h6);
    rc(32'h180, 32'h0);
    chk(irq, 0);
    $display("interrupt test done");
  endtask : t_irq
  task results;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    t_mix;
    t_level;
    t_stat;
    t_irq;
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    results;
  end
endmodule : rlm_right_mixer_regs_tb
`default_nettype wire
